/* common/adc_port_defs.svh */
// Constants for the converter host control port: offsets, fields, resets, timing
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_RESULT      8'h08
`define OFS_IRQ_STAT    8'h0C
`define OFS_IRQ_MASK    8'h10

// ==========================================================
// Field positions
`define CTRL_PORT_EN    0
`define CTRL_SW_START   1
`define CTRL_SW_LEN8    2
`define STAT_BUSY       0
`define STAT_LEN8       1
`define IRQ_DONE        0
`define IRQ_IGNORED     1

// ==========================================================
// Reset values
`define CTRL_RST        3'h1
`define IRQ_MASK_RST    2'h0

// ==========================================================
// Timing: clock period and one approximation step, both in ns
`define CLK_PERIOD_NS   10
`define STEP_NS         100
`define STEP_CYC        ((`STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* common/adc_port_pkg.sv */
// Types shared by the converter host control port modules
package adc_port_pkg;

    // ==========================================================
    // Sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_STEP,
        SEQ_LATCH
    } seq_state_t;

endpackage

/* common/sar_if.sv */
// Carrier between the port control logic and the approximation sequencer
`timescale 1ns/1ns
interface sar_if;
    logic        start;   // One-cycle start of a conversion
    logic        len8;    // Short (8-bit) conversion when high
    logic [11:0] sample;  // Input code offered to the hold stage
    logic        done;    // One-cycle pulse, result just latched
    logic [11:0] result;  // Last latched result

    modport ctrl (output start, output len8, output sample, input done, input result);
    modport seq  (input start, input len8, input sample, output done, output result);
endinterface

/* src/adc_host_control_port.sv */
// Host control port of a 12-bit sampling converter with an APB register file
//
// Functional notes
// R1 - Start when enabled, selected, convert requested
// R2 - Simultaneous changes still start, same delay
// R3 - Host holds other start inputs 50ns before
// R4 - Busy high only during a conversion
// R5 - Result pins float while busy
// R6 - Start edges ignored during conversion
// R7 - Start edge while busy relatches length
// R8 - Length select one gives 8 bits
// R9 - Chip enable high needed; rise may start
// R10 - Select low needed; fall may start
// R11 - Convert low needed; fall may start
// R12 - Read only while read/convert high
// R13 - Word mode drives all twelve bits
// R14 - Byte mode: MSB byte or LSBs plus zeros
// R15 - Outputs need read, idle, enabled, selected
// R16 - Short conversion reads low nibble zero
// R17 - Fixed steps, busy drops after latch
//
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ns
`include "adc_port_defs.svh"
module adc_host_control_port
    import adc_port_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // APB slave
    input  wire logic [7:0]  paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Host control pins
    input  wire logic        ce_i,
    input  wire logic        cs_n_i,
    input  wire logic        rd_not_cv_i,
    input  wire logic        byte_or_length_sel_i,
    input  wire logic        data_width_sel_i,
    // Input code from the analog front end, same clock
    input  wire logic [11:0] sample_code_i,
    // Status and result pins
    output logic             busy_o,
    output logic      [11:0] result_bus_o,
    output logic      [11:0] result_bus_oe_o,
    output logic             irq_o
);

    // ==========================================================
    // Declarations
    sar_if sar ();

    logic [4:0]  meta_ff;         // First synchroniser stage
    logic [4:0]  sync_ff;         // Second stage, the only one read
    logic        ce_s;            // Synchronised chip enable
    logic        cs_n_s;          // Synchronised select, active low
    logic        rnc_s;           // Synchronised read/convert
    logic        sel_s;           // Synchronised length/byte select
    logic        dw_s;            // Synchronised data width select
    logic        cond_prev_ff;    // Start condition one cycle ago
    logic        cond_now;        // All three start inputs at level
    logic        cond_rise;       // Last of them just arrived
    logic        host_start;      // Accepted start from the pins
    logic        sw_start;        // Accepted start from software
    logic        start;           // Any accepted start
    logic        busy_ff;         // Conversion in progress
    logic        len8_ff;         // Latched conversion length
    logic        rd_en;           // Output enable conditions met
    logic [11:0] nxt_bus;
    logic [11:0] nxt_oe;
    logic [11:0] result_bus_ff;
    logic [11:0] result_bus_oe_ff;
    logic [2:0]  ctrl_ff;         // Port enable, soft start, soft length
    logic [1:0]  irq_stat_ff;     // Sticky events
    logic [1:0]  irq_mask_ff;     // Event enables
    logic        irq_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        apb_wr;          // Write takes effect this edge
    logic        ev_ignored;      // Start edge seen while busy
    logic [31:0] nxt_rdata;
    logic        nxt_err;

    // ==========================================================
    // Register address check, used by the error decode
    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_RESULT) ||
                     (a == `OFS_IRQ_STAT) || (a == `OFS_IRQ_MASK);
    endfunction

    // ==========================================================
    // Pin synchronisers; the host is asynchronous to this clock
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            // Idle select level, so no false select edge follows reset
            meta_ff <= 5'h02;
            sync_ff <= 5'h02;
        end else begin
            meta_ff <= {data_width_sel_i, byte_or_length_sel_i, rd_not_cv_i, cs_n_i, ce_i};
            sync_ff <= meta_ff;
        end
    end

    assign ce_s   = sync_ff[0];
    assign cs_n_s = sync_ff[1];
    assign rnc_s  = sync_ff[2];
    assign sel_s  = sync_ff[3];
    assign dw_s   = sync_ff[4];

    // ==========================================================
    // Start detection: one combined level, so whichever input arrives
    // last (or all at once) gives the same single edge and delay
    assign cond_now   = ce_s && !cs_n_s && !rnc_s; // R9 R10 R11
    assign cond_rise  = cond_now && !cond_prev_ff; // R1 R2
    assign host_start = cond_rise && !busy_ff && ctrl_ff[`CTRL_PORT_EN]; // R6
    assign apb_wr     = psel_i && penable_i && pready_ff && pwrite_i;
    assign sw_start   = apb_wr && (paddr_i == `OFS_CTRL) &&
                        pwdata_i[`CTRL_SW_START] && !busy_ff && !host_start;
    assign start      = host_start || sw_start;
    assign ev_ignored = cond_rise && busy_ff;

    // Previous start condition, for edge detection
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            cond_prev_ff <= 1'b0;
        end else begin
            cond_prev_ff <= cond_now;
        end
    end

    // ==========================================================
    // Length latch: every start edge with the port enabled latches it, even one that is
    // otherwise ignored mid-conversion, so the running length may change
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            len8_ff <= 1'b0;
        end else if (cond_rise && ctrl_ff[`CTRL_PORT_EN]) begin
            len8_ff <= sel_s; // R8 R7
        end else if (sw_start) begin
            len8_ff <= pwdata_i[`CTRL_SW_LEN8];
        end
    end

    // ==========================================================
    // Busy: rises with the start, falls the cycle after the result latch
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_ff <= 1'b0;
        end else if (start) begin
            busy_ff <= 1'b1; // R4
        end else if (sar.done) begin
            busy_ff <= 1'b0; // R4 R17
        end
    end

    // Sequencer hookup; length follows the live latch
    assign sar.start  = start;
    assign sar.len8   = start ? (host_start ? sel_s : pwdata_i[`CTRL_SW_LEN8]) : len8_ff;
    assign sar.sample = sample_code_i;

    sar_seq u_seq (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .sar       (sar)
    );

    // ==========================================================
    // Read path: enable only with all four conditions, format by width
    assign rd_en = rnc_s && !busy_ff && !start && ce_s && !cs_n_s; // R12 R15 R5

    always_comb begin
        nxt_bus = 12'h000;
        nxt_oe  = 12'h000;
        if (rd_en) begin
            if (dw_s) begin
                // Whole word, byte select ignored
                nxt_bus = sar.result; // R13
                nxt_oe  = 12'hFFF;
            end else if (!sel_s) begin
                // High byte on the upper eight lines
                nxt_bus = {sar.result[11:4], 4'h0}; // R14
                nxt_oe  = 12'hFF0;
            end else begin
                // Low nibble left-justified, trailing zeros forced
                nxt_bus = {sar.result[3:0], 4'h0, 4'h0}; // R14
                nxt_oe  = 12'hFF0;
            end
        end
    end

    // Registered pin drivers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            result_bus_ff    <= 12'h000;
            result_bus_oe_ff <= 12'h000;
        end else begin
            result_bus_ff    <= nxt_bus;
            result_bus_oe_ff <= nxt_oe;
        end
    end

    // ==========================================================
    // Control register; soft start bit reads back as zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctrl_ff <= `CTRL_RST;
        end else if (apb_wr && paddr_i == `OFS_CTRL) begin
            ctrl_ff <= {pwdata_i[`CTRL_SW_LEN8], 1'b0, pwdata_i[`CTRL_PORT_EN]};
        end
    end

    // ==========================================================
    // Interrupt status and mask; a new event wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= `IRQ_MASK_RST;
            irq_ff      <= 1'b0;
        end else begin
            irq_stat_ff <= (irq_stat_ff &
                            ~((apb_wr && paddr_i == `OFS_IRQ_STAT) ? pwdata_i[1:0] : 2'h0)) |
                           {ev_ignored, sar.done};
            if (apb_wr && paddr_i == `OFS_IRQ_MASK) begin
                irq_mask_ff <= pwdata_i[1:0];
            end
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ==========================================================
    // APB read data and error, prepared in the setup cycle
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = !addr_known(paddr_i);
        if (paddr_i == `OFS_CTRL) begin
            nxt_rdata = {29'h0, ctrl_ff};
        end else if (paddr_i == `OFS_STATUS) begin
            nxt_rdata = {30'h0, len8_ff, busy_ff};
        end else if (paddr_i == `OFS_RESULT) begin
            nxt_rdata = {20'h0, sar.result};
        end else if (paddr_i == `OFS_IRQ_STAT) begin
            nxt_rdata = {30'h0, irq_stat_ff};
        end else if (paddr_i == `OFS_IRQ_MASK) begin
            nxt_rdata = {30'h0, irq_mask_ff};
        end
    end

    // Ready high for exactly the first access cycle: no wait states
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (psel_i && !penable_i) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= nxt_err;
            prdata_ff  <= pwrite_i ? 32'h0000_0000 : nxt_rdata;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Outputs
    assign prdata_o        = prdata_ff;
    assign pready_o        = pready_ff;
    assign pslverr_o       = pslverr_ff;
    assign busy_o          = busy_ff;
    assign result_bus_o    = result_bus_ff;
    assign result_bus_oe_o = result_bus_oe_ff;
    assign irq_o           = irq_ff;

    // ==========================================================
    // Checks
    a_start_sets_busy: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R1
        host_start |=> busy_ff)
        else $error("accepted start did not raise busy");
    a_busy_floats_bus: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R5
        busy_ff |-> result_bus_oe_ff == 12'h000)
        else $error("result pins driven while busy");
    a_busy_ignores_edge: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R6
        cond_rise && busy_ff && !sar.done |-> !sar.start ##1 busy_ff)
        else $error("start edge acted on during conversion");
    a_len_relatch: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R7
        cond_rise && busy_ff && ctrl_ff[`CTRL_PORT_EN] |=> len8_ff == $past(sel_s))
        else $error("length not relatched by edge during conversion");
    a_len_on_start: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R8
        host_start |=> len8_ff == $past(sel_s))
        else $error("length not latched at start");
    a_busy_after_latch: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R17
        busy_ff && sar.done |=> !busy_ff && sar.result == $past(sar.result))
        else $error("busy did not fall after result latch");
    a_oe_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R15
        result_bus_oe_ff != 12'h000 |-> $past(rnc_s && ce_s && !cs_n_s && !busy_ff))
        else $error("outputs enabled without all read conditions");
    a_word_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R13
        rd_en && dw_s |=> result_bus_oe_ff == 12'hFFF && result_bus_ff == $past(sar.result))
        else $error("word read not driving all twelve bits");
    a_byte_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R14
        rd_en && !dw_s && sel_s |=> result_bus_oe_ff == 12'hFF0 && result_bus_ff[7:4] == 4'h0)
        else $error("low byte read malformed");

endmodule

/* src/sar_seq.sv */
// Successive approximation sequencer with its own step divider
`timescale 1ns/1ns
`include "adc_port_defs.svh"
module sar_seq
    import adc_port_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    sar_if.seq        sar
);

    // ==========================================================
    // Lowest bit index tried for the given length
    function automatic logic [3:0] last_bit(input logic len8);
        last_bit = len8 ? 4'h4 : 4'h0;
    endfunction

    seq_state_t  state_ff;    // Sequencer state
    logic [11:0] held_ff;     // Held sample
    logic [11:0] trial_ff;    // Bits decided so far
    logic [3:0]  bit_ff;      // Bit under test
    logic [7:0]  div_ff;      // Step divider
    logic        step_en;     // One-cycle step enable
    logic [11:0] cand;        // Trial with the tested bit set
    logic [11:0] result_ff;
    logic        done_ff;

    assign step_en = (div_ff == 8'(`STEP_CYC - 1));
    assign cand    = trial_ff | (12'h001 << bit_ff);
    assign sar.result = result_ff;
    assign sar.done   = done_ff;

    // ==========================================================
    // Step divider, restarted by each start so every step is full length
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || sar.start || step_en) begin
            div_ff <= 8'h00;
        end else if (state_ff == SEQ_STEP) begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // ==========================================================
    // Fixed step count per latched length; length read live so a relatch counts
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff  <= SEQ_IDLE;
            held_ff   <= 12'h000;
            trial_ff  <= 12'h000;
            bit_ff    <= 4'hB;
            result_ff <= 12'h000;
            done_ff   <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                SEQ_IDLE: begin
                    if (sar.start) begin
                        held_ff  <= sar.sample;
                        trial_ff <= 12'h000;
                        bit_ff   <= 4'hB;
                        state_ff <= SEQ_STEP; // R17
                    end
                end
                SEQ_STEP: begin
                    if (step_en) begin
                        if (cand <= held_ff) begin
                            trial_ff <= cand;
                        end
                        // Ending at or below the limit covers a late switch to short
                        if (bit_ff <= last_bit(sar.len8)) begin
                            state_ff <= SEQ_LATCH; // R17
                        end else begin
                            bit_ff <= bit_ff - 4'h1;
                        end
                    end
                end
                SEQ_LATCH: begin
                    // Short result keeps the low nibble at zero
                    result_ff <= sar.len8 ? {trial_ff[11:4], 4'h0} : trial_ff; // R16
                    done_ff   <= 1'b1; // R17
                    state_ff  <= SEQ_IDLE;
                end
                default: begin
                    state_ff <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    a_short_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R16
        done_ff && $past(sar.len8) |-> result_ff[3:0] == 4'h0)
        else $error("short conversion left low nibble set");
    a_latch_done: assert property (@(posedge clk_i) disable iff (sys_rst_i) // R17
        state_ff == SEQ_LATCH |=> done_ff && state_ff == SEQ_IDLE)
        else $error("result latch not followed by done");

endmodule

/* tb/host_pins_model.sv */
// Host-side control logic that drives the converter's start and read pins
`timescale 1ns/1ns
module host_pins_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] mode_i,      // 0 idle, 1 convert, 2 read
    input  wire logic [1:0] gate_i,      // Bit 0 keeps enable low, bit 1 keeps select high
    output logic            ce_o,
    output logic            cs_n_o,
    output logic            rd_not_cv_o
);
    logic [2:0] hold_ff;                 // Cycles the enables have been stable

    // ==========================================================
    // Pin sequencing
    // Enables settle first so the convert line is the one that triggers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ce_o        <= 1'b0;
            cs_n_o      <= 1'b1;
            rd_not_cv_o <= 1'b1;
            hold_ff     <= 3'h0;
        end else begin
            ce_o    <= (mode_i != 2'h0) && !gate_i[0];
            cs_n_o  <= (mode_i == 2'h0) || gate_i[1];
            hold_ff <= (mode_i != 2'h1) ? 3'h0 : (hold_ff == 3'h7) ? hold_ff : hold_ff + 3'h1;
            // Falls only after 60 ns of stable enables
            rd_not_cv_o <= !((mode_i == 2'h1) && (hold_ff >= 3'h6));
        end
    end
endmodule

/* tb/tb.sv */
// Self-checking testbench for the converter host control port
`timescale 1ns/1ns
module tb;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr;
    logic [1:0]  mode = 2'h0, gate = 2'h0;
    logic        ce, cs_n, rnc, sel = 1'b0, wide = 1'b1;
    logic [11:0] sample = 12'h000, bus, oe;
    logic        busy, irq;
    logic [31:0] q;
    logic        e;
    int          failures = 0, compares = 0, n;

    always #5 clk_i = ~clk_i;

    host_pins_model host_u (.clk_i(clk_i), .rst_i(sys_rst_i), .mode_i(mode), .gate_i(gate),
        .ce_o(ce), .cs_n_o(cs_n), .rd_not_cv_o(rnc));

    adc_host_control_port dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .paddr_i(paddr),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .ce_i(ce),
        .cs_n_i(cs_n), .rd_not_cv_i(rnc), .byte_or_length_sel_i(sel),
        .data_width_sel_i(wide), .sample_code_i(sample), .busy_o(busy),
        .result_bus_o(bus), .result_bus_oe_o(oe), .irq_o(irq));

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            failures++;
            $display("Error t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        // Sampled at the rising edge: values seen are those before the edge
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clk_i);
            k++;
        end
        if (k == 20) begin
            failures++;
            stop_test();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Start a conversion and count busy cycles; optional retrigger mid-run
    task automatic conv(input logic len8, input logic rt);
        int k;
        k = 0;
        @(posedge clk_i);
        sel <= len8;
        mode <= 2'h1;
        while (busy !== 1'b1 && k < 40) begin
            @(posedge clk_i);
            k++;
        end
        @(negedge clk_i);
        chk(busy, 1'b1);
        chk(oe, 12'h000);
        n = 0;
        if (rt) begin
            repeat (10) @(posedge clk_i);
            sel <= 1'b1;
            mode <= 2'h2;
            repeat (3) @(posedge clk_i);
            mode <= 2'h1;
            n = 13;
        end
        wait_idle();
        mode <= 2'h0;
        repeat (3) @(posedge clk_i);
    endtask

    // Count cycles in n until busy falls; a hang ends the run as a failure
    task automatic wait_idle();
        while (busy === 1'b1 && n < 400) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 400) begin
            failures++;
            stop_test();
        end
    endtask

    // Read through the pins and judge enables and driven bits
    task automatic rd(input logic w, input logic s, input logic [11:0] v, input logic [11:0] en);
        @(posedge clk_i);
        wide <= w;
        sel <= s;
        mode <= 2'h2;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        chk(oe, en);
        chk(bus & oe, v);
        @(posedge clk_i);
        mode <= 2'h0;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        chk(oe, 12'h000);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        apb(8'h00, 1'b0, 32'h0);
        chk(q, 32'h1);
        apb(8'h10, 1'b0, 32'h0);
        chk(q, 32'h0);
        apb(8'h14, 1'b0, 32'h0);
        chk(e, 1'b1);
        apb(8'h10, 1'b1, 32'h1);
    endtask

    task automatic t_conv12();
        sample <= 12'hABC;
        conv(1'b0, 1'b0);
        chk(n > 100, 1'b1);
        chk(irq, 1'b1);
        rd(1'b1, 1'b1, 12'hABC, 12'hFFF);
        rd(1'b0, 1'b0, 12'hAB0, 12'hFF0);
        rd(1'b0, 1'b1, 12'hC00, 12'hFF0);
        apb(8'h08, 1'b0, 32'h0);
        chk(q, 32'hABC);
        apb(8'h0C, 1'b1, 32'h1);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(irq, 1'b0);
    endtask

    task automatic t_conv8();
        apb(8'h10, 1'b1, 32'h0);
        conv(1'b1, 1'b0);
        chk(n < 100, 1'b1);
        chk(irq, 1'b0);
        rd(1'b1, 1'b0, 12'hAB0, 12'hFFF);
        apb(8'h04, 1'b0, 32'h0);
        chk(q, 32'h2);
        apb(8'h10, 1'b1, 32'h1);
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk(irq, 1'b1);
        apb(8'h0C, 1'b1, 32'h1);
    endtask

    task automatic t_retrig();
        conv(1'b0, 1'b1);
        chk(n > 30, 1'b1);
        chk(n < 100, 1'b1);
        apb(8'h0C, 1'b0, 32'h0);
        chk(q[1], 1'b1);
        apb(8'h0C, 1'b1, 32'h3);
    endtask

    task automatic t_gate();
        for (int g = 1; g < 3; g++) begin
            @(posedge clk_i);
            gate <= g[1:0];
            mode <= 2'h1;
            repeat (40) @(posedge clk_i);
            @(negedge clk_i);
            chk(busy, 1'b0);
            @(posedge clk_i);
            mode <= 2'h2;
            repeat (6) @(posedge clk_i);
            @(negedge clk_i);
            chk(oe, 12'h000);
            @(posedge clk_i);
            mode <= 2'h0;
        end
        gate <= 2'h0;
        repeat (4) @(posedge clk_i);
    endtask

    // Port disable blocks pin starts; a soft start runs a short conversion
    task automatic t_soft();
        apb(8'h00, 1'b1, 32'h0);
        @(posedge clk_i);
        mode <= 2'h1;
        repeat (30) @(posedge clk_i);
        @(negedge clk_i);
        chk(busy, 1'b0);
        @(posedge clk_i);
        mode <= 2'h0;
        sample <= 12'h5A3;
        apb(8'h00, 1'b1, 32'h7);
        @(negedge clk_i);
        chk(busy, 1'b1);
        n = 0;
        wait_idle();
        chk(n < 100, 1'b1);
        apb(8'h08, 1'b0, 32'h0);
        chk(q, 32'h5A0);
        apb(8'h00, 1'b1, 32'h1);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_regs();
        t_conv12();
        t_conv8();
        t_retrig();
        t_gate();
        t_soft();
        stop_test();
    end

    // Whole run is under a thousand cycles; this leaves a wide margin
    initial begin
        #300000;
        failures++;
        stop_test();
    end
endmodule
